// ==== core/program_sequencer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module program_sequencer #(
	parameter LARGE_VARIANT = 1
) (
	input wire core_clk,
	input wire rst_b,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire op_valid,
	input wire [1:0] op_kind,
	input wire [8:0] op_target,
	input wire [7:0] op_literal,
	input wire [4:0] file_addr,
	input wire file_rd,
	input wire file_wr,
	input wire [7:0] file_wdata,
	output reg [7:0] file_rdata,
	output wire [6:0] mem_addr,
	output wire mem_rd,
	output wire mem_wr,
	output wire [7:0] mem_wdata,
	input wire [7:0] mem_rdata,
	output wire [9:0] program_counter,
	output reg w_load,
	output reg [7:0] w_load_data
);

// state held here
reg [`PC_W-1:0] pc_r;
reg [`PC_W-1:0] pc_nxt;
reg page_r;
reg page_nxt;
reg [6:0] ptr_r;
reg [6:0] ptr_nxt;

// stack and address translation results
wire [`STACK_W-1:0] stack_l1;
wire [`STACK_W-1:0] stack_l2;
wire [4:0] eff_offset;
wire [1:0] eff_bank;
wire via_pointer;
wire self_ref;

// qualified instruction-cycle actions
wire do_call;
wire do_return;
wire do_jump;
wire file_rd_q;
wire file_wr_q;
wire local_pc_low;
wire local_pointer;
wire file_pc_write;
wire file_ptr_write;

// apb phases
wire apb_setup;
wire apb_write;
wire apb_pc_write;
wire apb_ptr_write;
wire apb_page_write;
reg [31:0] apb_rdata;
reg apb_bad;

// pointer as software sees it, unimplemented top bits read as ones
function [7:0] pointer_view;
	input [6:0] p;
	begin
		if (LARGE_VARIANT != 0)
			pointer_view = {1'b1, p};
		else
			pointer_view = {2'b11, p[5:0]};
	end
endfunction

// storage form of a pointer write; bits the variant lacks stay low
function [6:0] pointer_store;
	input [7:0] d;
	begin
		if (LARGE_VARIANT != 0)
			pointer_store = d[6:0];
		else
			pointer_store = {1'b0, d[5:0]};
	end
endfunction

// next sequential address, ten bits so the top wraps to zero
function [`PC_W-1:0] pc_step;
	input [`PC_W-1:0] p;
	begin
		pc_step = p + 10'h001;
	end
endfunction

// counter load for call and low-byte writes: page, bit 8 low, byte
function [`PC_W-1:0] pc_low_load;
	input pg;
	input [7:0] b;
	begin
		pc_low_load = {pg, 1'b0, b};
	end
endfunction

// decoder strobes only count inside an instruction cycle
assign do_jump = op_valid && (op_kind == `OP_JUMP);
assign do_call = op_valid && (op_kind == `OP_CALL);
assign do_return = op_valid && (op_kind == `OP_RETURN);
assign file_rd_q = op_valid && file_rd;
assign file_wr_q = op_valid && file_wr;

// translate the file address, window goes through the pointer
indirect_map #(
	.LARGE_VARIANT(LARGE_VARIANT)
) u_indirect (
	.file_addr(file_addr),
	.pointer(ptr_r),
	.eff_offset(eff_offset),
	.eff_bank(eff_bank),
	.via_pointer(via_pointer),
	.self_ref(self_ref)
);

// counter low byte and pointer live here, not in the memory
assign local_pc_low = (eff_offset == `FILE_PC_LOW);
assign local_pointer = (eff_offset == `FILE_POINTER);
assign file_pc_write = file_wr_q && local_pc_low;
assign file_ptr_write = file_wr_q && local_pointer;

// memory strobes; a self-referencing window access is dropped
assign mem_addr = {eff_bank, eff_offset};
assign mem_rd = file_rd_q && !self_ref && !local_pc_low && !local_pointer;
assign mem_wr = file_wr_q && !self_ref && !local_pc_low && !local_pointer;
assign mem_wdata = file_wdata;

// return stack: push pc+1 on call, pop on return
return_stack #(
	.W(`STACK_W)
) u_stack (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.push(do_call),
	.pop(do_return),
	.push_data({2'b00, pc_step(pc_r)}),
	.level1(stack_l1),
	.level2(stack_l2)
);

// apb decode; zero wait states so pready is tied high
assign pready = 1'b1;
assign apb_setup = psel && !penable;
assign apb_write = psel && penable && pwrite;
assign apb_pc_write = apb_write && (paddr == `APB_PC_LOW);
assign apb_ptr_write = apb_write && (paddr == `APB_POINTER);
assign apb_page_write = apb_write && (paddr == `APB_PAGE);

// counter next state; the decoder's instruction outranks a bus write
always @* begin
	pc_nxt = pc_r;
	if (op_valid) begin
		case (op_kind)
		`OP_JUMP: begin
			pc_nxt = {page_r, op_target};
		end
		`OP_CALL: begin
			pc_nxt = pc_low_load(page_r, op_target[7:0]);
		end
		`OP_RETURN: begin
			pc_nxt = stack_l1[`PC_W-1:0];
		end
		default: begin
			if (file_pc_write)
				pc_nxt = pc_low_load(page_r, file_wdata);
			else
				pc_nxt = pc_step(pc_r);
		end
		endcase
	end else if (apb_pc_write) begin
		pc_nxt = pc_low_load(page_r, pwdata[7:0]);
	end
end

// page preselect only changes from the bus
always @* begin
	page_nxt = page_r;
	if (apb_page_write)
		page_nxt = pwdata[`APB_PAGE_BIT];
end

// pointer: instruction write first, bus write whenever the instruction does not write the pointer
always @* begin
	ptr_nxt = ptr_r;
	if (file_ptr_write)
		ptr_nxt = pointer_store(file_wdata);
	else if (apb_ptr_write)
		ptr_nxt = pointer_store(pwdata[7:0]);
end

// state registers; reset lands on the calibration slot, page 0
always @(posedge core_clk) begin
	if (!rst_b) begin
		pc_r <= `PC_RESET;
		page_r <= `PAGE_RESET;
		ptr_r <= `POINTER_RESET;
	end else begin
		pc_r <= pc_nxt;
		page_r <= page_nxt;
		ptr_r <= ptr_nxt;
	end
end

assign program_counter = pc_r;

// file read data, one cycle after the read strobe
always @(posedge core_clk) begin
	if (!rst_b) begin
		file_rdata <= 8'h00;
	end else if (file_rd_q) begin
		if (self_ref)
			file_rdata <= `INDIRECT_NULL;
		else if (local_pc_low)
			file_rdata <= pc_r[7:0];
		else if (local_pointer)
			file_rdata <= pointer_view(ptr_r);
		else
			file_rdata <= mem_rdata;
	end
end

// accumulator load pulse carrying the return literal
always @(posedge core_clk) begin
	if (!rst_b) begin
		w_load <= 1'b0;
		w_load_data <= 8'h00;
	end else begin
		w_load <= do_return;
		if (do_return)
			w_load_data <= op_literal;
	end
end

// apb read mux; unmapped offsets answer zero with an error
always @* begin
	apb_rdata = 32'h0000_0000;
	apb_bad = 1'b0;
	case (paddr)
	`APB_PC_LOW: begin
		apb_rdata = {24'h000000, pc_r[7:0]};
	end
	`APB_POINTER: begin
		apb_rdata = {24'h000000, pointer_view(ptr_r)};
	end
	`APB_PAGE: begin
		apb_rdata = {26'h0, page_r, 5'h00};
	end
	`APB_PC: begin
		apb_rdata = {22'h0, pc_r};
	end
	`APB_STACK1: begin
		apb_rdata = {20'h00000, stack_l1};
	end
	`APB_STACK2: begin
		apb_rdata = {20'h00000, stack_l2};
	end
	default: begin
		apb_bad = 1'b1;
	end
	endcase
end

// answer captured in setup so it is stable for the access phase
always @(posedge core_clk) begin
	if (!rst_b) begin
		prdata <= 32'h0000_0000;
		pslverr <= 1'b0;
	end else if (apb_setup) begin
		prdata <= pwrite ? 32'h0000_0000 : apb_rdata;
		pslverr <= apb_bad;
	end else if (!psel) begin
		pslverr <= 1'b0;
	end
end

endmodule
`default_nettype wire

// ==== core/seq_map.vh ====
// Contract
// - counter steps by one each instruction cycle
// - jump loads counter bits 8:0 from target
// - counter low byte readable and writable register
// - counter bit 9 taken from page preselect
// - call or low-byte write clears bit 8
// - reset to last location, then wrap 00h
// - reset clears page preselect to page 0
// - return stack two deep, twelve bits wide
// - call copies level one down, pushes pc+1
// - deeper calls keep two newest addresses only
// - return loads level one, level two up
// - extra returns repeat old level two address
// - return also loads accumulator with literal
// - no overflow or underflow flag at all
// - indirect window redirects through the pointer
// - indirect read of window itself gives 00h
// - indirect write of window itself stores nothing
// - pointer low five bits pick 00h-1Fh
// - large variant: bits 6:5 bank, bit 7 one
// - small variant: bit 5 bank, bits 7:6 one
// - page bit set page 1, clear page 0
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

// counter and stack geometry
`define PC_W 10
`define PC_RESET 10'h3ff
`define STACK_W 12
`define PAGE_RESET 1'b0
`define POINTER_RESET 7'h00
`define INDIRECT_NULL 8'h00

// instruction kinds from the decoder
`define OP_STEP 2'h0
`define OP_JUMP 2'h1
`define OP_CALL 2'h2
`define OP_RETURN 2'h3

// data register space addresses
`define FILE_INDIRECT 5'h00
`define FILE_PC_LOW 5'h02
`define FILE_POINTER 5'h04

// apb byte offsets
`define APB_PC_LOW 8'h00
`define APB_POINTER 8'h04
`define APB_PAGE 8'h08
`define APB_PC 8'h0c
`define APB_STACK1 8'h10
`define APB_STACK2 8'h14
`define APB_PAGE_BIT 5

`endif

// ==== core/return_stack.v ====
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module return_stack #(
	parameter W = `STACK_W
) (
	input wire core_clk,
	input wire rst_b,
	input wire push,
	input wire pop,
	input wire [W-1:0] push_data,
	output wire [W-1:0] level1,
	output wire [W-1:0] level2
);

reg [W-1:0] level1_r;
reg [W-1:0] level2_r;

// two physical levels only; no depth counter, so nothing flags over/underflow
always @(posedge core_clk) begin
	if (!rst_b) begin
		level1_r <= {W{1'b0}};
		level2_r <= {W{1'b0}};
	end else if (push) begin
		level2_r <= level1_r;
		level1_r <= push_data;
	end else if (pop) begin
		level1_r <= level2_r;
	end
end

assign level1 = level1_r;
assign level2 = level2_r;

endmodule
`default_nettype wire

// ==== core/indirect_map.v ====
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module indirect_map #(
	parameter LARGE_VARIANT = 1
) (
	input wire [4:0] file_addr,
	input wire [6:0] pointer,
	output wire [4:0] eff_offset,
	output wire [1:0] eff_bank,
	output wire via_pointer,
	output wire self_ref
);

// window address swaps in the pointer; direct accesses pass through
assign via_pointer = (file_addr == `FILE_INDIRECT);
assign eff_offset = via_pointer ? pointer[4:0] : file_addr;
// the window pointing at itself has no storage behind it
assign self_ref = via_pointer && (pointer[4:0] == `FILE_INDIRECT);
// bank bits differ per variant, unused bank bit held low
assign eff_bank = LARGE_VARIANT ? pointer[6:5] : {1'b0, pointer[5]};

endmodule
`default_nettype wire

// ==== testbench/data_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
	input wire logic core_clk,
	input wire logic [6:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [128];
	logic [7:0] last_r;
	// seeded pattern so reads can be predicted
	initial begin
		for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
		last_r = 8'h00;
	end
	always @(posedge core_clk) begin
		if (mem_wr) mem[mem_addr] <= mem_wdata;
		if (mem_rd) last_r <= mem_rdata;
	end
	// unread bus shows inverted data, so a stale value cannot pass
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_r;
endmodule
`default_nettype wire

// ==== testbench/seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"
module seq_properties (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic [8:0] op_target,
	input wire logic [7:0] op_literal,
	input wire logic file_wr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [6:0] mem_addr,
	input wire logic [9:0] program_counter,
	input wire logic w_load,
	input wire logic [7:0] w_load_data
);
	wire is_call = op_valid && op_kind == `OP_CALL;
	wire is_ret = op_valid && op_kind == `OP_RETURN;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// low-byte writes reload instead of stepping
	a_pc_step: assert property (
		op_valid && op_kind == `OP_STEP && !file_wr |=> program_counter == $past(program_counter) + 10'h001
	) else $error("pc step");
	a_jump_low: assert property (
		op_valid && op_kind == `OP_JUMP |=> program_counter[8:0] == $past(op_target)
	) else $error("jump target");
	a_call_low: assert property (
		is_call |=> program_counter[8:0] == {1'h0, $past(op_target[7:0])}
	) else $error("call target");
	a_call_ret: assert property (
		is_call ##1 is_ret |=> program_counter == $past(program_counter, 2) + 10'h001
	) else $error("return address");
	a_ret_literal: assert property (
		is_ret |=> w_load && w_load_data == $past(op_literal)
	) else $error("literal load");
	a_wload_cause: assert property (
		w_load |-> $past(is_ret)
	) else $error("stray literal load");
	a_idle_quiet: assert property (
		!op_valid |-> !mem_rd && !mem_wr
	) else $error("idle strobe");
	// the window pointing at itself must never reach the memory
	a_self_read: assert property (
		mem_rd |-> mem_addr[4:0] != 5'h00
	) else $error("self read forwarded");
	a_self_write: assert property (
		mem_wr |-> mem_addr[4:0] != 5'h00
	) else $error("self write forwarded");
	a_reset_pc: assert property (
		@(posedge core_clk) disable iff (1'h0) !rst_b |=> program_counter == `PC_RESET
	) else $error("pc reset");
	c_two_calls: cover property (is_call ##1 is_call);
	c_call_ret: cover property (is_call ##1 is_ret);
	c_mem_wr: cover property (mem_wr);
	c_two_rets: cover property (is_ret ##1 is_ret);
endmodule
bind program_sequencer seq_properties seq_properties_inst (.core_clk, .rst_b, .op_valid, .op_kind,
	.op_target, .op_literal, .file_wr, .mem_rd, .mem_wr, .mem_addr, .program_counter, .w_load, .w_load_data);
`default_nettype wire

// ==== testbench/test_program_counter_stack_indirect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"
module test_program_counter_stack_indirect;
	logic core_clk, rst_b, psel, penable, pwrite, op_valid, file_rd, file_wr, err;
	logic [7:0] paddr, op_literal, file_wdata;
	logic [31:0] pwdata, rd;
	logic [1:0] op_kind;
	logic [8:0] op_target;
	logic [4:0] file_addr;
	wire [31:0] prdata;
	wire pready, pslverr, mem_rd, mem_wr, w_load;
	wire [7:0] file_rdata, mem_wdata, mem_rdata, w_load_data;
	wire [6:0] mem_addr;
	wire [9:0] program_counter;
	int n_errors = 0;
	int checked = 0;
	program_sequencer program_sequencer_inst (.core_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .op_valid, .op_kind, .op_target, .op_literal, .file_addr,
		.file_rd, .file_wr, .file_wdata, .file_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
		.mem_rdata, .program_counter, .w_load, .w_load_data);
	data_mem_model data_mem_model_inst (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
	task automatic report_and_stop;
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// one bus transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk);
			if (pready === 1'h1) break;
		end
		if (i == 8) begin
			n_errors++;
			report_and_stop;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// leaves op_valid high so ops can run back to back
	task automatic op(input logic [1:0] k, input logic [8:0] t, input logic r, input logic w,
		input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		op_valid <= 1'h1;
		op_kind <= k;
		op_target <= t;
		op_literal <= t[7:0];
		file_rd <= r;
		file_wr <= w;
		file_addr <= a;
		file_wdata <= d;
	endtask
	task automatic fin;
		@(posedge core_clk);
		op_valid <= 1'h0;
		file_rd <= 1'h0;
		file_wr <= 1'h0;
		#1;
	endtask
	task automatic t_reset;
		chk("pc", 32'h3ff, program_counter);
		apb(1'h0, `APB_PAGE, 32'h0);
		chk("page", 32'h0, rd);
		op(`OP_STEP, 9'h0, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h0, program_counter);
		op(`OP_STEP, 9'h0, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h1, program_counter);
	endtask
	task automatic t_branch;
		op(`OP_JUMP, 9'h1a5, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h1a5, program_counter);
		apb(1'h1, `APB_PAGE, 32'h20);
		op(`OP_JUMP, 9'h0f0, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h2f0, program_counter);
		op(`OP_CALL, 9'h134, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h234, program_counter);
		apb(1'h0, `APB_STACK1, 32'h0);
		chk("lvl1", 32'h2f1, rd);
	endtask
	task automatic t_stack;
		op(`OP_CALL, 9'h010, 1'h0, 1'h0, 5'h0, 8'h0);
		op(`OP_CALL, 9'h020, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		apb(1'h0, `APB_STACK2, 32'h0);
		chk("lvl2", 32'h235, rd);
		op(`OP_RETURN, 9'h0a5, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h211, program_counter);
		chk("wload", 32'h1a5, {w_load, w_load_data});
		op(`OP_RETURN, 9'h03c, 1'h0, 1'h0, 5'h0, 8'h0);
		op(`OP_RETURN, 9'h00f, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h235, program_counter);
		op(`OP_CALL, 9'h050, 1'h0, 1'h0, 5'h0, 8'h0);
		op(`OP_RETURN, 9'h011, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h236, program_counter);
	endtask
	task automatic t_ind;
		apb(1'h1, `APB_POINTER, 32'h27);
		apb(1'h0, `APB_POINTER, 32'h0);
		chk("ptr", 32'ha7, rd);
		op(`OP_STEP, 9'h0, 1'h1, 1'h0, `FILE_INDIRECT, 8'h0);
		fin;
		chk("ind", 32'h7d, file_rdata);
		op(`OP_STEP, 9'h0, 1'h0, 1'h1, `FILE_INDIRECT, 8'hc3);
		op(`OP_STEP, 9'h0, 1'h1, 1'h0, `FILE_INDIRECT, 8'h0);
		fin;
		chk("ind", 32'hc3, file_rdata);
		apb(1'h1, `APB_POINTER, 32'h20);
		op(`OP_STEP, 9'h0, 1'h1, 1'h0, `FILE_INDIRECT, 8'h0);
		fin;
		chk("self", 32'h0, file_rdata);
		op(`OP_STEP, 9'h0, 1'h0, 1'h1, `FILE_INDIRECT, 8'h99);
		fin;
		chk("self", 32'h7a, data_mem_model_inst.mem[7'h20]);
		apb(1'h0, 8'h40, 32'h0);
		chk("slverr", 32'h1, err);
		chk("unmap", 32'h0, rd);
		op(`OP_STEP, 9'h0, 1'h0, 1'h1, `FILE_PC_LOW, 8'h80);
		fin;
		chk("pc", 32'h280, program_counter);
	endtask
	// bus counter load, data-space counter and pointer access, then a reset in mid-run
	task automatic t_regs;
		apb(1'h1, `APB_PC_LOW, 32'h5c);
		apb(1'h0, `APB_PC, 32'h0);
		chk("pc", 32'h25c, rd);
		op(`OP_STEP, 9'h0, 1'h1, 1'h0, `FILE_PC_LOW, 8'h0);
		op(`OP_STEP, 9'h0, 1'h0, 1'h1, `FILE_POINTER, 8'h13);
		fin;
		chk("pclow", 32'h5c, file_rdata);
		op(`OP_STEP, 9'h0, 1'h1, 1'h0, `FILE_POINTER, 8'h0);
		fin;
		chk("ptr", 32'h93, file_rdata);
		apb(1'h0, `APB_PC_LOW, 32'h0);
		chk("pclow", 32'h5f, rd);
		@(posedge core_clk);
		rst_b <= 1'h0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'h1;
		#1;
		chk("pc", 32'h3ff, program_counter);
		apb(1'h0, `APB_PAGE, 32'h0);
		chk("page", 32'h0, rd);
		apb(1'h0, `APB_POINTER, 32'h0);
		chk("ptr", 32'h80, rd);
		op(`OP_STEP, 9'h0, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h0, program_counter);
		op(`OP_JUMP, 9'h0f0, 1'h0, 1'h0, 5'h0, 8'h0);
		fin;
		chk("pc", 32'h0f0, program_counter);
	endtask
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		{rst_b, psel, penable, pwrite, op_valid, file_rd, file_wr, paddr, op_literal} = '0;
		{file_wdata, pwdata, op_kind, op_target, file_addr} = '0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'h1;
		t_reset;
		t_branch;
		t_stack;
		t_ind;
		t_regs;
		report_and_stop;
	end
endmodule
`default_nettype wire
